//--- inc/hci_defines.svh
`ifndef HCI_DEFINES_SVH
`define HCI_DEFINES_SVH
// ****************************************
// command codes
// ****************************************
`define HCI_C_FCLR 8'h40
`define HCI_C_FSET 8'h41
`define HCI_C_MBWR 4'h5
`define HCI_C_MBRD 4'h6
`define HCI_C_PING 8'h70
`define HCI_C_STAT 4'h8
`define HCI_C_PRD 8'h90
`define HCI_C_PCLR 8'hA0
`define HCI_C_PSET 8'hA1
`define HCI_C_MEM 8'hB0
`define HCI_C_DAC0 8'hC0
`define HCI_C_DAC1 8'hC1
`define HCI_C_DOFF0 8'hC2
`define HCI_C_DOFF1 8'hC3
`define HCI_C_ADCMV 8'hD0
`define HCI_C_ADCMON 8'hD9
`define HCI_C_LOOP0 8'hDA
`define HCI_C_LOOP1 8'hDB
// ****************************************
// reply bytes
// ****************************************
`define HCI_R_RUN 8'hC3
`define HCI_R_STOP 8'hE8
`define HCI_R_TMO 8'hE8
`define HCI_E_CMD 8'hE1
`define HCI_E_CLR 8'hE2
`define HCI_E_SET 8'hE3
`define HCI_E_RD 8'hE4
`define HCI_R_PASS 8'h01
`define HCI_R_FAIL 8'h00
`define HCI_R_LO 8'h00
`define HCI_R_HI 8'h01
// ****************************************
// fields and indices
// ****************************************
`define HCI_MB_HI_BIT 3
`define HCI_STAT_MAX 4'hA
`define HCI_STAT_SUB 4'h0
`define HCI_STAT_SR 4'h3
`define HCI_PIN_BASE 8'd16
`define HCI_PIN_LAST 8'd31
`define HCI_BCD_MAX 4'h9
`define HCI_FAB_CODES 64'h6824222019181716
// ****************************************
// timing, memory, converter
// ****************************************
`define HCI_CLK_KHZ 50000
`define HCI_WDOG_MS 2000
`define HCI_FWD_MS 2000
`define HCI_SRAM_WORDS 262144
`define HCI_SRAM_DW 16
`define HCI_MEM_PATTERN 16'hA55A
`define HCI_ADC_BITS 12
`define HCI_MV_FULL 2500
`endif

//--- inc/hci_pkg.sv
package hci_pkg;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } hci_byte_t;
  typedef enum logic [2:0] {ST_IDLE, ST_ARG, ST_FWD, ST_MEM, ST_SEND1, ST_SEND2} hci_state_t;
  typedef enum logic [2:0] {FK_STATUS, FK_ADC_MV, FK_ADC_MON, FK_LOOP0, FK_LOOP1} hci_fwd_kind_t;
  typedef struct packed {
    hci_fwd_kind_t kind;
    logic [3:0] index;
  } hci_fwd_req_t;
  typedef struct packed {
    logic fabric_soft_reset;
    logic external_soft_reset;
    logic second_serial_soft_reset;
    logic first_serial_soft_reset;
  } hci_soft_reset_t;
  typedef struct packed {
    logic [7:0] out_status;
    logic [7:0] out_command;
    logic [7:0] out_data_lo;
    logic [7:0] out_data_hi;
    logic [7:0] in_status;
    logic [7:0] in_command;
    logic [7:0] in_data_lo;
    logic [7:0] in_data_hi;
  } hci_mailbox_t;
endpackage

//--- logic/hci_memtest.sv
`timescale 1ns/1ps
`include "hci_defines.svh"
module hci_memtest #(
  parameter int WORDS = `HCI_SRAM_WORDS,
  parameter int AW = $clog2(WORDS)
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic start,
  output logic [AW-1:0] sram_addr,
  output logic [`HCI_SRAM_DW-1:0] sram_wdata,
  output logic sram_we,
  output logic sram_re,
  input wire logic [`HCI_SRAM_DW-1:0] sram_rdata,
  output logic done,
  output logic pass
);
  typedef enum logic [1:0] {MT_IDLE, MT_WRITE, MT_READ, MT_LAST} hci_mt_state_t;
  hci_mt_state_t st_q;
  logic [AW-1:0] addr_q;
  logic [AW-1:0] chk_q;
  logic chk_v_q;
  logic ok_q;
  logic done_q;
  // pattern depends on the low 16 address bits so aliasing on those lines shows up
  function automatic logic [`HCI_SRAM_DW-1:0] pattern(input logic [AW-1:0] a);
    pattern = `HCI_SRAM_DW'(a) ^ `HCI_MEM_PATTERN;
  endfunction
  assign sram_addr = addr_q;
  assign sram_wdata = pattern(addr_q);
  assign sram_we = (st_q == MT_WRITE);
  assign sram_re = (st_q == MT_READ);
  assign done = done_q;
  assign pass = ok_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= MT_IDLE;
      addr_q <= '0;
    end else begin
      case (st_q)
        MT_IDLE: if (start) begin
          st_q <= MT_WRITE;
          addr_q <= '0;
        end
        MT_WRITE: begin
          addr_q <= addr_q + 1'b1;
          if (addr_q == AW'(WORDS - 1)) st_q <= MT_READ;
        end
        MT_READ: begin
          addr_q <= addr_q + 1'b1;
          if (addr_q == AW'(WORDS - 1)) st_q <= MT_LAST;
        end
        MT_LAST: st_q <= MT_IDLE;
        default: st_q <= MT_IDLE;
      endcase
    end
  end
  // read data arrives one cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      chk_q <= '0;
      chk_v_q <= 1'b0;
      ok_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      chk_q <= addr_q;
      chk_v_q <= (st_q == MT_READ);
      done_q <= (st_q == MT_LAST);
      if (st_q == MT_IDLE && start) ok_q <= 1'b1;
      else if (chk_v_q && sram_rdata != pattern(chk_q)) ok_q <= 1'b0;
    end
  end
endmodule // hci_memtest

//--- logic/hci_top.sv
`timescale 1ns/1ps
`include "hci_defines.svh"
// What this block does
// - set-fabric-pin with valid code drives that output high, echoes code
// - mailbox write: 0x5n then value, stored at location n
// - mailbox write replies with its command byte, not the value
// - locations 0-3 outbound fields, 4-7 the same fields inbound
// - 0x6n returns mailbox location n
// - processor ping returns running or stopped byte
// - processor counts as stopped after two seconds without activity
// - 0x8n returns processor status value n, index A is build number
// - status index 0 carries lock-lost bit 5 and lock-gained bit 4
// - status index 3 carries four soft reset bits 7 to 4
// - subsystem pin read takes pin code 0x16-0x31 as decimal pin
// - pin read returns 0x00 for low, 0x01 for high
// - pin clear drives the pin low, echoes the code
// - pin set drives the pin high, echoes the code
// - memory test writes then reads all words, returns pass or fail
// - DAC configure loads second byte, enables DAC, echoes byte
// - DAC disable codes turn one DAC off each
// - millivolt command returns converted sample, high byte first
// - raw commands return 12-bit count right-justified, high byte first
// - loop tests sample an ADC through its internal DAC link
// - codes 0x16, 0x17, 0x18, 0x19, 0x20, 0x22, 0x24, 0x68 map to fabric output bits 0-7
// - every command is one or two bytes and gets its reply
// - unknown first byte returns the invalid command error
// - forwarded command unanswered for two seconds returns timeout error
module hci_top
#(
  parameter int WDOG_CYCLES = `HCI_WDOG_MS * `HCI_CLK_KHZ,
  parameter int FWD_CYCLES = `HCI_FWD_MS * `HCI_CLK_KHZ,
  parameter int SRAM_WORDS = `HCI_SRAM_WORDS,
  parameter int SRAM_AW = $clog2(SRAM_WORDS)
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire hci_pkg::hci_byte_t host_rx,
  output logic host_rx_ready,
  output hci_pkg::hci_byte_t host_tx,
  input wire logic host_tx_ready,
  output hci_pkg::hci_mailbox_t mb_image,
  input wire logic mb_proc_we,
  input wire logic [2:0] mb_proc_addr,
  input wire logic [7:0] mb_proc_wdata,
  input wire logic proc_activity,
  output logic fwd_valid,
  output hci_pkg::hci_fwd_req_t fwd_req,
  input wire logic fwd_ack,
  input wire logic [15:0] fwd_data,
  input wire logic clock_lock_lost_flag,
  input wire logic clock_lock_gained_flag,
  input wire hci_pkg::hci_soft_reset_t soft_reset_value,
  input wire logic [15:0] sub_pin_in,
  output logic [15:0] sub_pin_out,
  output logic [15:0] sub_pin_oe_n,
  output logic [7:0] fab_out,
  output logic [7:0] dac0_value,
  output logic dac0_enable,
  output logic [7:0] dac1_value,
  output logic dac1_enable,
  output logic [SRAM_AW-1:0] sram_addr,
  output logic [`HCI_SRAM_DW-1:0] sram_wdata,
  output logic sram_we,
  output logic sram_re,
  input wire logic [`HCI_SRAM_DW-1:0] sram_rdata
);
  import hci_pkg::*;
  localparam int WW = $clog2(WDOG_CYCLES + 1);
  localparam int FW = $clog2(FWD_CYCLES + 1);
  hci_state_t state_q, state_d;
  logic [7:0] cmd_q, b;
  logic [15:0] reply_q, reply_d, fwd_reply;
  logic two_q, two_d, mem_go, mt_done, mt_pass, alive_q;
  hci_fwd_req_t fwd_q, fwd_d;
  logic [7:0] mb_q [8];
  logic take, take1, take2, pin_ok, fab_ok;
  logic [3:0] pin_ix;
  logic [2:0] fab_ix;
  logic [WW-1:0] wd_q;
  logic [FW-1:0] tmo_q;
  logic [23:0] mv_prod;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic needs_arg(input logic [7:0] c);
    needs_arg = c == `HCI_C_FCLR || c == `HCI_C_FSET || c == `HCI_C_PRD || c == `HCI_C_PCLR
      || c == `HCI_C_PSET || c == `HCI_C_DAC0 || c == `HCI_C_DAC1
      || (c[7:4] == `HCI_C_MBWR && !c[`HCI_MB_HI_BIT]);
  endfunction
  function automatic logic [7:0] bcd_val(input logic [7:0] c);
    bcd_val = 8'(c[7:4]) * 8'd10 + 8'(c[3:0]);
  endfunction
  function automatic logic sub_pin_valid(input logic [7:0] c);
    sub_pin_valid = c[3:0] <= `HCI_BCD_MAX && c[7:4] <= `HCI_BCD_MAX
      && bcd_val(c) >= `HCI_PIN_BASE && bcd_val(c) <= `HCI_PIN_LAST;
  endfunction
  function automatic logic [3:0] sub_pin_index(input logic [7:0] c);
    sub_pin_index = 4'(bcd_val(c) - `HCI_PIN_BASE);
  endfunction
  always_comb begin
    logic [63:0] codes;
    codes = `HCI_FAB_CODES;
    fab_ok = 1'b0;
    fab_ix = '0;
    for (int i = 0; i < 8; i++) begin
      if (codes[8*i +: 8] == b) begin
        fab_ok = 1'b1;
        fab_ix = 3'(i);
      end
    end
  end
  assign b = host_rx.data;
  assign pin_ok = sub_pin_valid(b);
  assign pin_ix = sub_pin_index(b);
  assign host_rx_ready = (state_q == ST_IDLE) || (state_q == ST_ARG);
  assign take = host_rx.valid && host_rx_ready;
  assign take1 = take && state_q == ST_IDLE;
  assign take2 = take && state_q == ST_ARG;
  assign host_tx.valid = (state_q == ST_SEND1) || (state_q == ST_SEND2);
  assign host_tx.data = reply_q[15:8];
  assign fwd_valid = (state_q == ST_FWD);
  assign fwd_req = fwd_q;
  // ****************************************
  // forwarded answers
  // ****************************************
  assign mv_prod = 24'(fwd_data[`HCI_ADC_BITS-1:0]) * 24'(`HCI_MV_FULL);
  always_comb begin
    case (fwd_q.kind)
      FK_STATUS: begin
        fwd_reply = {fwd_data[7:0], 8'h00};
        if (fwd_q.index == `HCI_STAT_SUB)
          fwd_reply[13:12] = {clock_lock_lost_flag, clock_lock_gained_flag};
        if (fwd_q.index == `HCI_STAT_SR)
          fwd_reply[15:12] = soft_reset_value;
      end
      FK_ADC_MV: fwd_reply = 16'(mv_prod >> `HCI_ADC_BITS);
      default: fwd_reply = {4'h0, fwd_data[`HCI_ADC_BITS-1:0]};
    endcase
  end
  // ****************************************
  // command sequencer
  // ****************************************
  always_comb begin
    state_d = state_q;
    reply_d = reply_q;
    two_d = two_q;
    fwd_d = fwd_q;
    mem_go = 1'b0;
    case (state_q)
      ST_IDLE: if (host_rx.valid) begin
        state_d = ST_SEND1;
        two_d = 1'b0;
        reply_d = {b, 8'h00};
        if (needs_arg(b)) state_d = ST_ARG;
        else if (b == `HCI_C_PING) reply_d[15:8] = alive_q ? `HCI_R_RUN : `HCI_R_STOP;
        else if (b[7:4] == `HCI_C_MBRD && !b[`HCI_MB_HI_BIT]) reply_d[15:8] = mb_q[b[2:0]];
        else if (b[7:4] == `HCI_C_STAT && b[3:0] <= `HCI_STAT_MAX) begin
          state_d = ST_FWD;
          fwd_d = '{FK_STATUS, b[3:0]};
        end else if (b == `HCI_C_MEM) begin
          state_d = ST_MEM;
          mem_go = 1'b1;
        end else if (b == `HCI_C_DOFF0 || b == `HCI_C_DOFF1) reply_d[15:8] = b;
        else if (b == `HCI_C_ADCMV || b == `HCI_C_ADCMON || b == `HCI_C_LOOP0 || b == `HCI_C_LOOP1) begin
          state_d = ST_FWD;
          fwd_d.index = b[3:0];
          fwd_d.kind = b == `HCI_C_ADCMV ? FK_ADC_MV : b == `HCI_C_ADCMON ? FK_ADC_MON
            : b == `HCI_C_LOOP0 ? FK_LOOP0 : FK_LOOP1;
        end else reply_d[15:8] = `HCI_E_CMD;
      end
      ST_ARG: if (host_rx.valid) begin
        state_d = ST_SEND1;
        two_d = 1'b0;
        reply_d = {cmd_q, 8'h00};
        case (cmd_q)
          `HCI_C_FCLR: reply_d[15:8] = fab_ok ? b : `HCI_E_CLR;
          `HCI_C_FSET: reply_d[15:8] = fab_ok ? b : `HCI_E_SET;
          `HCI_C_PRD: reply_d[15:8] = !pin_ok ? `HCI_E_RD : sub_pin_in[pin_ix] ? `HCI_R_HI : `HCI_R_LO;
          `HCI_C_PCLR: reply_d[15:8] = pin_ok ? b : `HCI_E_CLR;
          `HCI_C_PSET: reply_d[15:8] = pin_ok ? b : `HCI_E_SET;
          `HCI_C_DAC0, `HCI_C_DAC1: reply_d[15:8] = b;
          default: reply_d = {cmd_q, 8'h00};
        endcase
      end
      ST_FWD: if (fwd_ack) begin
        state_d = ST_SEND1;
        two_d = fwd_q.kind != FK_STATUS;
        reply_d = fwd_reply;
      end else if (tmo_q == FW'(FWD_CYCLES - 1)) begin
        state_d = ST_SEND1;
        two_d = 1'b0;
        reply_d = {`HCI_R_TMO, 8'h00};
      end
      ST_MEM: if (mt_done) begin
        state_d = ST_SEND1;
        reply_d = {mt_pass ? `HCI_R_PASS : `HCI_R_FAIL, 8'h00};
      end
      ST_SEND1: if (host_tx_ready) begin
        state_d = two_q ? ST_SEND2 : ST_IDLE;
        reply_d = {reply_q[7:0], 8'h00};
      end
      ST_SEND2: if (host_tx_ready) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      reply_q <= '0;
      two_q <= 1'b0;
      fwd_q <= '{FK_STATUS, 4'h0};
      cmd_q <= '0;
    end else begin
      state_q <= state_d;
      reply_q <= reply_d;
      two_q <= two_d;
      fwd_q <= fwd_d;
      if (take1) cmd_q <= b;
    end
  end
  // ****************************************
  // mailbox
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) for (int i = 0; i < 8; i++) mb_q[i] <= '0;
    else if (take2 && cmd_q[7:4] == `HCI_C_MBWR) begin
      mb_q[cmd_q[2:0]] <= b;
    end else if (mb_proc_we) begin
      mb_q[mb_proc_addr] <= mb_proc_wdata;
    end
  end
  assign mb_image = {mb_q[0], mb_q[1], mb_q[2], mb_q[3], mb_q[4], mb_q[5], mb_q[6], mb_q[7]};
  // ****************************************
  // pins and converters
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sub_pin_out <= '0;
      sub_pin_oe_n <= '1;
    end else if (take2 && (cmd_q == `HCI_C_PCLR || cmd_q == `HCI_C_PSET) && pin_ok) begin
      sub_pin_out[pin_ix] <= cmd_q == `HCI_C_PSET;
      sub_pin_oe_n[pin_ix] <= 1'b0;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) fab_out <= '0;
    else if (take2 && (cmd_q == `HCI_C_FCLR || cmd_q == `HCI_C_FSET) && fab_ok)
      fab_out[fab_ix] <= cmd_q == `HCI_C_FSET;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dac0_value <= '0;
      dac0_enable <= 1'b0;
      dac1_value <= '0;
      dac1_enable <= 1'b0;
    end else begin
      if (take2 && cmd_q == `HCI_C_DAC0) {dac0_enable, dac0_value} <= {1'b1, b};
      else if (take1 && b == `HCI_C_DOFF0) dac0_enable <= 1'b0;
      if (take2 && cmd_q == `HCI_C_DAC1) {dac1_enable, dac1_value} <= {1'b1, b};
      else if (take1 && b == `HCI_C_DOFF1) dac1_enable <= 1'b0;
    end
  end
  // ****************************************
  // watchdog and forward timeout
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wd_q <= '0;
      alive_q <= 1'b0;
    end else if (proc_activity) begin
      wd_q <= '0;
      alive_q <= 1'b1;
    end else if (alive_q) begin
      wd_q <= wd_q + 1'b1;
      if (wd_q == WW'(WDOG_CYCLES - 1)) alive_q <= 1'b0;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) tmo_q <= '0;
    else tmo_q <= state_q == ST_FWD ? tmo_q + 1'b1 : '0;
  end
  hci_memtest #(.WORDS(SRAM_WORDS), .AW(SRAM_AW)) u_memtest (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(mem_go),
    .sram_addr(sram_addr),
    .sram_wdata(sram_wdata),
    .sram_we(sram_we),
    .sram_re(sram_re),
    .sram_rdata(sram_rdata),
    .done(mt_done),
    .pass(mt_pass)
  );
  // ****************************************
  // checks
  // ****************************************
  mb_store_a: assert property (take2 && cmd_q[7:4] == `HCI_C_MBWR |=> mb_q[$past(cmd_q[2:0])] == $past(b))
    else $error("mailbox write not stored");
  mb_echo_a: assert property (take2 && cmd_q[7:4] == `HCI_C_MBWR |=> host_tx.valid && host_tx.data == $past(cmd_q))
    else $error("mailbox write echo wrong");
  mb_read_a: assert property (take1 && b[7:4] == `HCI_C_MBRD && !b[3] |=> host_tx.data == $past(mb_q[b[2:0]]))
    else $error("mailbox read wrong");
  ping_reply_a: assert property (take1 && b == `HCI_C_PING
    |=> host_tx.data == ($past(alive_q) ? `HCI_R_RUN : `HCI_R_STOP))
    else $error("ping reply wrong");
  wdog_stop_a: assert property (alive_q && !proc_activity && wd_q == WW'(WDOG_CYCLES - 1) |=> !alive_q)
    else $error("watchdog did not expire");
  pin_set_a: assert property (take2 && cmd_q == `HCI_C_PSET && pin_ok
    |=> sub_pin_out[$past(pin_ix)] && !sub_pin_oe_n[$past(pin_ix)] && host_tx.data == $past(b))
    else $error("pin set failed");
  pin_bad_a: assert property (take2 && (cmd_q == `HCI_C_PSET || cmd_q == `HCI_C_PCLR) && !pin_ok
    |=> $stable(sub_pin_out) && $stable(sub_pin_oe_n) && host_tx.data[7:4] == 4'hE)
    else $error("bad pin code not rejected");
  fab_set_a: assert property (take2 && cmd_q == `HCI_C_FSET && fab_ok |=> fab_out[$past(fab_ix)] ##0 host_tx.data == $past(b))
    else $error("fabric set failed");
  bad_cmd_a: assert property (take1 && b == 8'hFF |=> host_tx.valid && host_tx.data == `HCI_E_CMD)
    else $error("unknown command not flagged");
  fwd_tmo_a: assert property (state_q == ST_FWD && !fwd_ack && tmo_q == FW'(FWD_CYCLES - 1)
    |=> host_tx.valid && host_tx.data == `HCI_R_TMO)
    else $error("timeout reply missing");
  order_a: assert property (host_tx.valid |-> !host_rx_ready
    ##1 ($past(host_tx_ready) || host_tx.valid && $stable(host_tx.data)))
    else $error("byte taken while replying");
  sub_bits_a: assert property (state_q == ST_FWD && fwd_ack && fwd_q.kind == FK_STATUS && fwd_q.index == 4'h0
    |=> host_tx.data[5:4] == $past({clock_lock_lost_flag, clock_lock_gained_flag}))
    else $error("lock flags missing");
  sr_bits_a: assert property (fwd_valid && fwd_ack && fwd_q.kind == FK_STATUS && fwd_q.index == `HCI_STAT_SR
    |=> host_tx.data[7:4] == $past(soft_reset_value))
    else $error("soft reset bits missing");
  raw_a: assert property (state_q == ST_FWD && fwd_ack && fwd_q.kind == FK_ADC_MON
    |=> reply_q == {4'h0, $past(fwd_data[`HCI_ADC_BITS-1:0])} && host_tx.valid)
    else $error("raw sample format wrong");
  dac_a: assert property (take2 && cmd_q == `HCI_C_DAC1 |=> dac1_enable && dac1_value == $past(b))
    else $error("dac load failed");
  mem_c: cover property (state_q == ST_MEM ##1 mt_done);
  tmo_c: cover property (state_q == ST_FWD && tmo_q == FW'(FWD_CYCLES - 1) && !fwd_ack);
  two_c: cover property (state_q == ST_SEND2 && host_tx_ready);
  mbw_c: cover property (take2 && cmd_q[7:4] == `HCI_C_MBWR);
endmodule // hci_top

//--- testbench/hci_proc_model.sv
`timescale 1ns/1ps
// ****************************************
// processor subsystem and sram stand-in
// ****************************************
module hci_proc_model
  import hci_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic mute,
  input wire logic fwd_valid,
  input wire hci_pkg::hci_fwd_req_t fwd_req,
  output logic fwd_ack,
  output logic [15:0] fwd_data,
  input wire logic [3:0] sram_addr,
  input wire logic [15:0] sram_wdata,
  input wire logic sram_we,
  input wire logic sram_re,
  output logic [15:0] sram_rdata
);
  logic [1:0] wait_q;
  logic [15:0] mem_q [16];
  // answer after a few cycles; data wanders when not answering
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 2'h0;
      fwd_ack <= 1'b0;
      fwd_data <= 16'hFFFF;
      sram_rdata <= 16'hFFFF;
    end else begin
      fwd_ack <= 1'b0;
      fwd_data <= ~fwd_data;
      sram_rdata <= sram_re ? mem_q[sram_addr] : ~sram_rdata;
      if (fwd_valid && !mute && !fwd_ack) begin
        wait_q <= wait_q + 2'h1;
        if (wait_q == 2'h3) begin
          fwd_ack <= 1'b1;
          fwd_data <= {4'h0, 8'hA5, fwd_req.index};
        end
      end else begin
        wait_q <= 2'h0;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (sram_we) begin
      mem_q[sram_addr] <= sram_wdata;
    end
  end
endmodule // hci_proc_model

//--- testbench/hci_top_tb.sv
`timescale 1ns/1ps
module hci_top_tb;
  import hci_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  hci_byte_t host_rx = '0;
  logic host_tx_ready = 1'b0;
  logic mb_proc_we = 1'b0;
  logic [2:0] mb_proc_addr = 3'h0;
  logic [7:0] mb_proc_wdata = 8'h00;
  logic proc_activity = 1'b0;
  logic mute = 1'b0;
  logic [15:0] sub_pin_in = 16'h0080;
  logic lock_lost = 1'b1;
  logic lock_gained = 1'b0;
  hci_soft_reset_t soft_rst = 4'hA;
  logic host_rx_ready, fwd_valid, fwd_ack, dac0_enable, dac1_enable, sram_we, sram_re;
  hci_byte_t host_tx;
  hci_mailbox_t mb_image;
  hci_fwd_req_t fwd_req;
  logic [15:0] fwd_data, sub_pin_out, sub_pin_oe_n, sram_wdata, sram_rdata;
  logic [7:0] fab_out, dac0_value, dac1_value;
  logic [3:0] sram_addr;
  int fails = 0;
  int samples_checked = 0;
  always #10 mclk = ~mclk;
  hci_top #(.WDOG_CYCLES(50), .FWD_CYCLES(50), .SRAM_WORDS(16), .SRAM_AW(4)) u_hci_top (
    .mclk(mclk), .rst_n(rst_n), .host_rx(host_rx), .host_rx_ready(host_rx_ready),
    .host_tx(host_tx), .host_tx_ready(host_tx_ready), .mb_image(mb_image), .mb_proc_we(mb_proc_we),
    .mb_proc_addr(mb_proc_addr), .mb_proc_wdata(mb_proc_wdata), .proc_activity(proc_activity),
    .fwd_valid(fwd_valid), .fwd_req(fwd_req), .fwd_ack(fwd_ack), .fwd_data(fwd_data),
    .clock_lock_lost_flag(lock_lost), .clock_lock_gained_flag(lock_gained), .soft_reset_value(soft_rst),
    .sub_pin_in(sub_pin_in), .sub_pin_out(sub_pin_out), .sub_pin_oe_n(sub_pin_oe_n), .fab_out(fab_out),
    .dac0_value(dac0_value), .dac0_enable(dac0_enable), .dac1_value(dac1_value), .dac1_enable(dac1_enable),
    .sram_addr(sram_addr), .sram_wdata(sram_wdata), .sram_we(sram_we), .sram_re(sram_re),
    .sram_rdata(sram_rdata));
  hci_proc_model u_hci_proc_model (
    .mclk(mclk), .rst_n(rst_n), .mute(mute), .fwd_valid(fwd_valid), .fwd_req(fwd_req),
    .fwd_ack(fwd_ack), .fwd_data(fwd_data), .sram_addr(sram_addr), .sram_wdata(sram_wdata),
    .sram_we(sram_we), .sram_re(sram_re), .sram_rdata(sram_rdata));
  // ****************************************
  // host side tasks
  // ****************************************
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(inout int n);
    @(posedge mclk) #1;
    n++;
    if (n > 2000) begin
      fails++;
      wrap_up();
    end
  endtask
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    host_rx = '{valid: 1'b1, data: b};
    while (host_rx_ready !== 1'b1) tick(n);
    @(posedge mclk) #1;
    host_rx = '0;
    @(posedge mclk) #1;
  endtask
  task automatic recv(input logic [7:0] exp);
    int n;
    n = 0;
    while (host_tx.valid !== 1'b1) tick(n);
    chk({8'h00, host_tx.data}, {8'h00, exp});
    host_tx_ready = 1'b1;
    @(posedge mclk) #1;
    host_tx_ready = 1'b0;
    @(posedge mclk) #1;
  endtask
  task automatic cmd(input logic [7:0] b, input logic [7:0] exp);
    send(b);
    recv(exp);
  endtask
  task automatic cmd2(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] exp);
    send(b0);
    send(b1);
    recv(exp);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge mclk);
    #1 rst_n = 1'b1;
    chk(sub_pin_oe_n, 16'hFFFF);
    cmd2(8'h52, 8'h3C, 8'h52);
    chk({8'h00, mb_image.out_data_lo}, 16'h003C);
    cmd2(8'h57, 8'hA7, 8'h57);
    cmd(8'h62, 8'h3C);
    cmd(8'h67, 8'hA7);
    mb_proc_we = 1'b1;
    mb_proc_addr = 3'h4;
    mb_proc_wdata = 8'h99;
    @(posedge mclk) #1;
    mb_proc_we = 1'b0;
    cmd(8'h64, 8'h99);
    cmd(8'h70, 8'hE8);
    proc_activity = 1'b1;
    @(posedge mclk) #1;
    proc_activity = 1'b0;
    cmd(8'h70, 8'hC3);
    repeat (60) @(posedge mclk);
    #1;
    cmd(8'h70, 8'hE8);
    cmd2(8'hA1, 8'h23, 8'h23);
    chk(sub_pin_out, 16'h0080);
    chk(sub_pin_oe_n, 16'hFF7F);
    cmd2(8'h90, 8'h23, 8'h01);
    cmd2(8'h90, 8'h31, 8'h00);
    cmd2(8'hA1, 8'h31, 8'h31);
    cmd2(8'hA0, 8'h23, 8'h23);
    chk(sub_pin_out, 16'h8000);
    cmd2(8'hA1, 8'h1A, 8'hE3);
    cmd2(8'hA0, 8'h32, 8'hE2);
    cmd2(8'h90, 8'h15, 8'hE4);
    chk(sub_pin_out, 16'h8000);
    cmd2(8'h41, 8'h68, 8'h68);
    chk({8'h00, fab_out}, 16'h0080);
    cmd2(8'hC0, 8'h80, 8'h80);
    cmd2(8'hC1, 8'hFF, 8'hFF);
    chk({dac0_value, dac1_value}, 16'h80FF);
    chk({14'h0, dac0_enable, dac1_enable}, 16'h0003);
    cmd(8'hC2, 8'hC2);
    chk({14'h0, dac0_enable, dac1_enable}, 16'h0001);
    cmd(8'hC3, 8'hC3);
    chk({14'h0, dac0_enable, dac1_enable}, 16'h0000);
    cmd(8'h80, 8'h60);
    cmd(8'h83, 8'hA3);
    cmd(8'h8A, 8'h5A);
    cmd(8'h8B, 8'hE1);
    cmd(8'hFF, 8'hE1);
    cmd(8'h58, 8'hE1);
    for (int i = 9; i < 12; i++) begin
      send({4'hD, 4'(i)});
      recv(8'h0A);
      recv({4'h5, 4'(i)});
    end
    send(8'hD0);
    recv(8'h06);
    recv(8'h4B);
    mute = 1'b1;
    cmd(8'hD9, 8'hE8);
    mute = 1'b0;
    cmd(8'hB0, 8'h01);
    cmd(8'h62, 8'h3C);
    wrap_up();
  end
endmodule // hci_top_tb
